//--- hw/kwu_pkg.sv
// Package for the keypad wake unit: register map, field positions and the
// packed carriers shared by the top module and the pin detector.
// Assumes an APB register bus with 32-bit data and one word per register.
package kwu_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] KWU_OFF_STATUS_CONTROL = 12'h000;
	localparam logic [11:0] KWU_OFF_PIN_ENABLES = 12'h004;
	localparam logic [11:0] KWU_OFF_POLARITY_SELECT = 12'h008;
	localparam logic [11:0] KWU_OFF_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] KWU_OFF_IRQ_MASK = 12'h010;
	localparam logic [11:0] KWU_OFF_POWER_MODE = 12'h014;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int KWU_BIT_MODE = 0;
	localparam int KWU_BIT_IRQ_ENABLE = 1;
	localparam int KWU_BIT_ACK = 2;
	localparam int KWU_BIT_FLAG = 3;
	localparam int KWU_BIT_WAIT = 0;
	localparam int KWU_BIT_STOP = 1;
	localparam int KWU_BIT_ST_EVENT = 0;
	localparam int KWU_BIT_ST_WAKE = 1;

	// Implemented pins 5, 4, 2, 1, 0; bits 7, 6 and 3 are absent.
	localparam logic [7:0] KWU_PIN_MASK = 8'h37;
	localparam logic [7:0] KWU_STATUS_MASK = 8'h03;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] KWU_RST_CTRL = 8'h00;
	localparam logic [7:0] KWU_RST_PINS = 8'h00;
	localparam logic [7:0] KWU_RST_POL = 8'h00;
	localparam logic [31:0] KWU_RST_RDATA = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] pin_enable;
		logic [7:0] polarity;
		logic level_mode;
	} kwu_cfg_s;

	typedef struct packed {
		logic edge_hit;
		logic level_hit;
	} kwu_det_s;

	typedef enum logic [2:0] {
		KWU_RUN = 3'b001,
		KWU_WAIT = 3'b010,
		KWU_STOP = 3'b100
	} kwu_power_e;

endpackage

//--- hw/kwu_detect.sv
// Pin edge and level detector for the keypad wake unit.
// Assumes the key pins are already synchronous to pclk.
`timescale 1ns/10ps
module kwu_detect #(
	parameter int PINS = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and configuration
	input wire logic [PINS-1:0] key_input_pin_n,
	input wire kwu_pkg::kwu_cfg_s cfg,
	// Detection result
	output kwu_pkg::kwu_det_s det
);
	import kwu_pkg::*;

	// The configuration carrier holds eight pins, so more are refused.
	if (PINS < 1 || PINS > 8) begin : g_bad_pins
		$error("kwu_detect supports 1 to 8 pins");
	end

	logic [PINS-1:0] prev_q, prev_d;
	logic [PINS-1:0] active_now;
	logic [PINS-1:0] active_prev;

	// ----------------------------------------------------------------
	// Active level per pin
	// ----------------------------------------------------------------
	// A polarity of one makes high the active level, zero makes low.
	assign active_now = ~(key_input_pin_n ^ cfg.polarity[PINS-1:0]);
	assign active_prev = ~(prev_q ^ cfg.polarity[PINS-1:0]);

	always_comb begin
		prev_d = key_input_pin_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// Edge: inactive on one cycle and active on the next, enabled pins only.
	assign det.edge_hit = |(cfg.pin_enable[PINS-1:0] & active_now &
		~active_prev);
	assign det.level_hit = cfg.level_mode &
		(|(cfg.pin_enable[PINS-1:0] & active_now));

endmodule

//--- hw/kwu_top.sv
// Keypad wake unit: five key pins, one shared event flag, two interrupt
// requests (key_irq and irq) and a wake request for wait and stop.
// Assumes an APB master on pclk and key pins synchronous to pclk.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps

// Contract
// - Each key pin has its own enable.
// - Edge-only or edge-plus-level, either polarity.
// - All pin events merge into one maskable request.
// - Detection runs in wait; event wakes from wait.
// - Detection works in stop; event wakes from stop.
// - Debug halt leaves detection running normally.
// - Status/control: flag, ack, enable, mode bits.
// - Pin enables in bits 5,4,2,1,0 only.
// - Polarity bits in bits 5,4,2,1,0 only.
// - Edge is inactive then active on cycles.
// - Polarity zero falling/low, one rising/high.
// - Event sets flag; ack write clears; irq.
// - Level mode keeps flag while pin active.
module kwu_top #(
	parameter int PINS = 8
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Key pins
	input wire logic [PINS-1:0] key_input_pin_n,
	// Requests to the processor
	output logic key_irq,
	output logic irq,
	output logic wake_req
);
	import kwu_pkg::*;

	// The register layout fixes the pin count, so other widths are refused.
	if (PINS != 8) begin : g_bad_pins
		$error("kwu_top supports only PINS of 8");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic flag_q, flag_d;
	logic irq_en_q, irq_en_d;
	logic mode_q, mode_d;
	logic [7:0] pin_en_q, pin_en_d;
	logic [7:0] pol_q, pol_d;
	logic [1:0] st_q, st_d;
	logic [1:0] mask_q, mask_d;
	kwu_power_e pwr_q, pwr_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d;
	logic key_irq_d, irq_d, wake_d;

	kwu_cfg_s cfg;
	kwu_det_s det;
	logic wr_acc, rd_acc, ack, event_hit, hit_reg;
	logic [7:0] wbyte;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic known_addr(input logic [11:0] a);
		known_addr = (a == KWU_OFF_STATUS_CONTROL) ||
			(a == KWU_OFF_PIN_ENABLES) ||
			(a == KWU_OFF_POLARITY_SELECT) ||
			(a == KWU_OFF_IRQ_STATUS) ||
			(a == KWU_OFF_IRQ_MASK) ||
			(a == KWU_OFF_POWER_MODE);
	endfunction

	function automatic logic wr_hit(input logic acc, input logic [11:0] a,
		input logic [11:0] off);
		wr_hit = acc && (a == off);
	endfunction

	// One-wait slave: pready is registered and rises after the first access
	// cycle, so a transfer completes on the second edge after setup.
	assign wr_acc = psel && penable && !pready && pwrite;
	assign rd_acc = psel && penable && !pready && !pwrite;
	assign hit_reg = known_addr(paddr);
	// Only byte lane 0 carries register bits; other lanes are ignored.
	assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

	// ----------------------------------------------------------------
	// Detection
	// ----------------------------------------------------------------
	// The power mode does not gate detection: it runs identically in run,
	// wait and debug halt, so only the enables decide. Stop keeps pclk
	// here; a fully clockless stop path belongs to the clock controller.
	assign cfg.pin_enable = pin_en_q & KWU_PIN_MASK;
	assign cfg.polarity = pol_q & KWU_PIN_MASK;
	assign cfg.level_mode = mode_q;

	kwu_detect #(
		.PINS(PINS)
	) u_detect (
		.pclk(pclk),
		.presetn(presetn),
		.key_input_pin_n(key_input_pin_n),
		.cfg(cfg),
		.det(det)
	);

	assign event_hit = det.edge_hit | det.level_hit;
	assign ack = wr_hit(wr_acc, paddr, KWU_OFF_STATUS_CONTROL) &&
		wbyte[KWU_BIT_ACK];

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Reserved pin positions are masked on write, so they read zero.
	always_comb begin
		irq_en_d = irq_en_q;
		mode_d = mode_q;
		pin_en_d = pin_en_q;
		pol_d = pol_q;
		if (wr_acc) begin
			case (paddr)
				KWU_OFF_STATUS_CONTROL: begin
					irq_en_d = wbyte[KWU_BIT_IRQ_ENABLE];
					mode_d = wbyte[KWU_BIT_MODE];
				end
				KWU_OFF_PIN_ENABLES: begin
					pin_en_d = wbyte & KWU_PIN_MASK;
				end
				KWU_OFF_POLARITY_SELECT: begin
					pol_d = wbyte & KWU_PIN_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= KWU_RST_CTRL[KWU_BIT_IRQ_ENABLE];
			mode_q <= KWU_RST_CTRL[KWU_BIT_MODE];
			pin_en_q <= KWU_RST_PINS;
			pol_q <= KWU_RST_POL;
		end else begin
			irq_en_q <= irq_en_d;
			mode_q <= mode_d;
			pin_en_q <= pin_en_d;
			pol_q <= pol_d;
		end
	end

	// ----------------------------------------------------------------
	// Shared event flag
	// ----------------------------------------------------------------
	always_comb begin
		// Set wins over the acknowledge, which also keeps the flag up
		// in level mode while an enabled pin stays active.
		flag_d = flag_q;
		if (ack) begin
			flag_d = 1'b0;
		end
		if (event_hit) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	// The wake bit records only events that end a low-power state, and a
	// clear that meets a new event in the same cycle loses to it.
	always_comb begin
		st_d = st_q;
		if (wr_hit(wr_acc, paddr, KWU_OFF_IRQ_STATUS)) begin
			st_d = st_q & ~(wbyte[1:0] & KWU_STATUS_MASK[1:0]);
		end
		if (event_hit) begin
			st_d[KWU_BIT_ST_EVENT] = 1'b1;
		end
		if (event_hit && irq_en_q && pwr_q != KWU_RUN) begin
			st_d[KWU_BIT_ST_WAKE] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= 2'h0;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		mask_d = mask_q;
		if (wr_hit(wr_acc, paddr, KWU_OFF_IRQ_MASK)) begin
			mask_d = wbyte[1:0] & KWU_STATUS_MASK[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 2'h0;
		end else begin
			mask_q <= mask_d;
		end
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	// Stop outranks wait when software sets both bits at once.
	always_comb begin
		pwr_d = pwr_q;
		if (wr_hit(wr_acc, paddr, KWU_OFF_POWER_MODE)) begin
			if (wbyte[KWU_BIT_STOP]) begin
				pwr_d = KWU_STOP;
			end else if (wbyte[KWU_BIT_WAIT]) begin
				pwr_d = KWU_WAIT;
			end else begin
				pwr_d = KWU_RUN;
			end
		end
		// A wake event returns the block's power state to run.
		if (flag_d && irq_en_d && pwr_q != KWU_RUN) begin
			pwr_d = KWU_RUN;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q <= KWU_RUN;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer and outputs
	// ----------------------------------------------------------------
	always_comb begin
		prdata_d = KWU_RST_RDATA;
		pready_d = psel && penable && !pready;
		pslverr_d = psel && penable && !pready && !hit_reg;
		if (rd_acc) begin
			case (paddr)
				KWU_OFF_STATUS_CONTROL: begin
					// Acknowledge bit and upper bits read as zero.
					prdata_d[KWU_BIT_FLAG] = flag_q;
					prdata_d[KWU_BIT_IRQ_ENABLE] = irq_en_q;
					prdata_d[KWU_BIT_MODE] = mode_q;
				end
				KWU_OFF_PIN_ENABLES: begin
					prdata_d[7:0] = pin_en_q & KWU_PIN_MASK;
				end
				KWU_OFF_POLARITY_SELECT: begin
					prdata_d[7:0] = pol_q & KWU_PIN_MASK;
				end
				KWU_OFF_IRQ_STATUS: begin
					prdata_d[1:0] = st_q;
				end
				KWU_OFF_IRQ_MASK: begin
					prdata_d[1:0] = mask_q;
				end
				KWU_OFF_POWER_MODE: begin
					prdata_d[KWU_BIT_WAIT] = (pwr_q == KWU_WAIT);
					prdata_d[KWU_BIT_STOP] = (pwr_q == KWU_STOP);
				end
				default: begin
				end
			endcase
		end
		key_irq_d = flag_d && irq_en_d;
		irq_d = |(st_d & mask_d);
		wake_d = flag_d && irq_en_d && (pwr_q != KWU_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= KWU_RST_RDATA;
			pready <= 1'b0;
			pslverr <= 1'b0;
			key_irq <= 1'b0;
			irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			key_irq <= key_irq_d;
			irq <= irq_d;
			wake_req <= wake_d;
		end
	end

endmodule

//--- verification/kwu_top_sva.sv
// Checker on the ports of the keypad wake unit.
// Assumes one pclk domain; it is bound to the top module below.
`timescale 1ns/10ps
module kwu_sva (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Requests
	input wire logic key_irq,
	input wire logic irq,
	input wire logic wake_req
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = pready && !pwrite;
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	property p_rdy;
		s_acc |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_qual;
		pready |-> psel && penable;
	endproperty
	a_qual: assert property (p_qual) else $error("stray ready");
	property p_idle;
		!pready |-> prdata == 32'h0 && !pslverr;
	endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_sc;
		rd && paddr == 12'h000 |-> (prdata & 32'hFFFFFFF4) == 32'h0;
	endproperty
	a_sc: assert property (p_sc) else $error("control zeros");
	// Bits 7, 6 and 3 have no pin behind them, so they must read zero.
	property p_pe;
		rd && (paddr == 12'h004 || paddr == 12'h008)
			|-> (prdata & 32'hFFFFFFC8) == 32'h0;
	endproperty
	a_pe: assert property (p_pe) else $error("pin zeros");
	property p_bad;
		pready && paddr > 12'h014 |-> pslverr && prdata == 32'h0;
	endproperty
	a_bad: assert property (p_bad) else $error("unmapped");
	property p_rst;
		$rose(presetn) |-> !key_irq && !irq && !wake_req;
	endproperty
	a_rst: assert property (p_rst) else $error("reset out");
	property p_wake;
		wake_req |-> key_irq;
	endproperty
	a_wake: assert property (p_wake) else $error("wake no irq");
	// The power state is back at run after one wake cycle.
	property p_pulse;
		wake_req |=> !wake_req;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long wake");
endmodule
bind kwu_top kwu_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .key_irq(key_irq), .irq(irq),
	.wake_req(wake_req));

//--- verification/kwu_keys.sv
// Switch model for the key pins of the keypad wake unit.
// Assumes levels change only just after a rising pclk edge.
`timescale 1ns/10ps
module kwu_keys (
	// Clock
	input wire logic pclk,
	// Pins
	output logic [7:0] pins
);
	// Switches always hold a firm level, so no floating state exists.
	initial pins = 8'h00;
	task automatic put(input logic [7:0] v);
		@(posedge pclk);
		pins <= v;
	endtask
endmodule

//--- verification/kwu_top_bench.sv
// Self-checking bench for the keypad wake unit, with a cycle model.
// Assumes the package, design, switch model and checker compile first.
`timescale 1ns/10ps
module kwu_top_bench;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, key_irq, irq, wake_req;
	logic [7:0] pins;
	logic [11:0] regs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C,
		12'h010, 12'h014};
	int fails = 0;
	int total_checks = 0;
	int pe, pol, ie, md, fl, st, mk, pw, prv, wk;
	kwu_top #(.PINS(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.key_input_pin_n(pins), .key_irq(key_irq), .irq(irq),
		.wake_req(wake_req));
	kwu_keys P (.pclk(pclk), .pins(pins));
	// ----------------------------------------------------------------
	// Model
	// ----------------------------------------------------------------
	function automatic int act(int p);
		return ~(p ^ pol) & pe;
	endfunction
	always @(posedge pclk) begin
		int a;
		int ev;
		int oi;
		int opw;
		a = act(pins);
		ev = (a & ~act(prv)) != 0 || (md && a != 0);
		prv = pins;
		oi = ie;
		opw = pw;
		if (!presetn) begin
			{pe, pol, ie, md, fl, st, mk, pw, wk} = '0;
		end else begin
			if (psel && penable && !pready && pwrite)
				case (paddr)
					12'h000: begin
						ie = pwdata[1];
						md = pwdata[0];
						if (pwdata[2])
							fl = 0;
					end
					12'h004: pe = pwdata & 8'h37;
					12'h008: pol = pwdata & 8'h37;
					12'h00C: st &= ~pwdata;
					12'h010: mk = pwdata & 3;
					12'h014: pw = pwdata[1] ? 2 : pwdata[0];
				endcase
			// An event in the acknowledge cycle wins over the clear.
			if (ev) begin
				fl = 1;
				st |= (oi && opw != 0) ? 3 : 1;
			end
			// Wake lasts one cycle: the power state returns to run.
			wk = fl && ie && opw != 0;
			if (wk)
				pw = 0;
		end
	end
	function automatic int want(logic [11:0] a);
		case (a)
			12'h000: return fl << 3 | ie << 1 | md;
			12'h004: return pe;
			12'h008: return pol;
			12'h00C: return st;
			12'h010: return mk;
			12'h014: return pw;
			default: return 0;
		endcase
	endfunction
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic cmp(string s, logic [31:0] g, logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		int e;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// The access edge reads the state that this edge has settled.
		#1;
		e = want(a);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		cmp("pready", pready, 1);
		psel <= 1'h0;
		penable <= 1'h0;
		if (!w)
			cmp("prdata", prdata, e);
		cmp("pslverr", pslverr, a > 12'h014);
	endtask
	task automatic outs();
		repeat (3) begin
			@(posedge pclk);
			#1;
			cmp("key_irq", key_irq, fl && ie);
			cmp("irq", irq, (st & mk) != 0);
			cmp("wake_req", wake_req, wk);
		end
	endtask
	task automatic edge_case(int m, int k, int p);
		int b;
		b = p ? 0 : 255;
		P.put(8'(b));
		bus(1, 12'h008, p ? 255 : 0);
		bus(1, 12'h004, 1 << k);
		bus(1, 12'h000, 6 | m);
		bus(1, 12'h00C, 3);
		bus(1, 12'h014, k % 3);
		outs();
		P.put(8'(b ^ (1 << k) ^ ($urandom & ~(1 << k))));
		outs();
		bus(0, 12'h000, 0);
		bus(1, 12'h000, 6 | m);
		bus(0, 12'h000, 0);
		bus(0, 12'h00C, 0);
		bus(0, 12'h014, 0);
		outs();
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Run
	// ----------------------------------------------------------------
	initial forever #4 pclk = ~pclk;
	initial begin
		#80000;
		fails++;
		close_out();
	end
	initial begin
		void'($urandom(18481));
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		foreach (regs[i])
			bus(0, regs[i], 0);
		$display("test reset done");
		for (int i = 0; i < 40; i++)
			bus(i % 2, regs[i / 2 % 5], $urandom);
		outs();
		$display("test registers done");
		bus(0, 12'h018, 0);
		bus(1, 12'hFFC, 32'hFF);
		$display("test unmapped done");
		bus(1, 12'h010, 3);
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 12; k++)
				edge_case(m, k / 2, k % 2);
		$display("test pins done");
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		foreach (regs[i])
			bus(0, regs[i], 0);
		outs();
		$display("test second reset done");
		close_out();
	end
endmodule
